// File: twi_target_pkg.sv
package twi_target_pkg;

  // ********************************************
  // Bus addresses and command codes
  // ********************************************
  localparam logic [6:0] ADDR_GND = 7'h48;        // 1001000b
  localparam logic [6:0] ADDR_VDD = 7'h49;        // 1001001b
  localparam logic [6:0] ADDR_SDA = 7'h4A;        // 1001010b
  localparam logic [6:0] ADDR_SCL = 7'h4B;        // 1001011b
  localparam logic [6:0] ADDR_GCALL = 7'h00;
  localparam logic [7:0] GC_RESET_CMD = 8'h06;
  localparam logic [4:0] HS_CODE_TOP = 5'h01;     // 00001xxxb, upper five bits
  localparam int HS_CODE_POS = 3;

  // ********************************************
  // Byte framing and register fields
  // ********************************************
  localparam logic [3:0] BIT_ACK = 4'h8;          // Rising edges before the ack clock
  localparam logic [3:0] BIT_DONE = 4'h9;         // Rising edges incl. the ack clock
  localparam int PTR_W = 2;
  localparam logic [PTR_W-1:0] PTR_RESET = 2'h0;
  localparam logic [PTR_W-1:0] PTR_CONV = 2'h0;
  localparam logic [PTR_W-1:0] PTR_CFG = 2'h1;
  localparam logic [PTR_W-1:0] PTR_LO = 2'h2;
  localparam logic [PTR_W-1:0] PTR_HI = 2'h3;
  localparam int REG_W = 16;

  // ********************************************
  // Timing
  // ********************************************
  localparam int CLK_HZ = 20_000_000;
  localparam int TIMEOUT_MS = 25;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int FILT_NS = 100;
  localparam int FILT_CYC = (FILT_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int FILT_HS_NS = 50;
  localparam int FILT_HS_CYC = (FILT_HS_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int FILT_CNT_W = 4;

  // ********************************************
  // Transaction states
  // ********************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_PTR,
    ST_GCMD,
    ST_DATA,
    ST_TX,
    ST_IGNORE
  } phase_t;

endpackage : twi_target_pkg

// File: line_filter.sv
`timescale 1ns/10ps
// Two-flop synchroniser followed by a stability filter
module line_filter
  import twi_target_pkg::*;
#(
  parameter int LEN_NORM = FILT_CYC,
  parameter int LEN_HS = FILT_HS_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic raw,
  input wire logic hs,
  output logic level
);

  logic s1_q;
  logic s2_q;
  logic level_q;
  logic [FILT_CNT_W-1:0] cnt_q;
  logic [FILT_CNT_W-1:0] len;

  initial begin
    if (LEN_NORM < 1 || LEN_HS < 1 || LEN_NORM >= (1 << FILT_CNT_W) ||
        LEN_HS >= (1 << FILT_CNT_W)) begin
      $error("line_filter: filter lengths out of range");
    end
  end

  // Synchroniser; first stage feeds only the second
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end

  assign len = hs ? FILT_CNT_W'(LEN_HS) : FILT_CNT_W'(LEN_NORM);

  // New level accepted once stable for len samples
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      level_q <= 1'b1;
      cnt_q <= '0;
    end else if (s2_q == level_q) begin
      cnt_q <= '0;
    end else if (cnt_q >= len - 4'h1) begin
      level_q <= s2_q;
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  assign level = level_q;

endmodule : line_filter

// File: twi_target.sv
`timescale 1ns/10ps
module twi_target
  import twi_target_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic strap_i,
  output logic [PTR_W-1:0] reg_sel,
  output logic reg_wr,
  output logic [REG_W-1:0] reg_wdata,
  input wire logic [REG_W-1:0] reg_rdata,
  output logic gc_reset,
  output logic hs_mode,
  output logic busy
);

  localparam int TO_W = 20;

  initial begin
    if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES >= (1 << TO_W)) begin
      $error("twi_target: TIMEOUT_CYCLES out of range");
    end
  end

  // ********************************************
  // Line conditioning and event detection
  // ********************************************
  logic scl_f;
  logic sda_f;
  logic strap_f;
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic hs_q;

  // Synchronise and filter both lines and the strap
  line_filter u_scl (.ref_clk(ref_clk), .nrst(nrst), .raw(scl_i), .hs(hs_q), .level(scl_f));
  line_filter u_sda (.ref_clk(ref_clk), .nrst(nrst), .raw(sda_i), .hs(hs_q), .level(sda_f));
  line_filter #(.LEN_NORM(1), .LEN_HS(1)) u_strap (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .raw(strap_i),
    .hs(hs_q),
    .level(strap_f)
  );

  // Previous filtered levels for edge finding
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_f;
      sda_prev_q <= sda_f;
    end
  end

  // Clock edges and bus conditions
  assign scl_rise = scl_f && !scl_prev_q;
  assign scl_fall = !scl_f && scl_prev_q;
  assign start_ev = scl_f && scl_prev_q && sda_prev_q && !sda_f;
  assign stop_ev = scl_f && scl_prev_q && !sda_prev_q && sda_f;

  // ********************************************
  // Transaction state
  // ********************************************
  phase_t state_q;
  phase_t pend_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic [7:0] hi_q;
  logic [REG_W-1:0] rd_q;
  logic [PTR_W-1:0] ptr_q;
  logic sda_low_q;
  logic mack_q;
  logic byte_idx_q;
  logic wr_q;
  logic [REG_W-1:0] wdata_q;
  logic gc_q;
  logic [TO_W-1:0] idle_cnt_q;
  logic timeout;
  logic [6:0] own_addr;
  logic hi_seen_q;
  logic lo_seen_q;
  logic neq_sda_q;

  // Idle timer: cleared by any line activity
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      idle_cnt_q <= '0;
    end else if (state_q == ST_IDLE || scl_rise || scl_fall || sda_f != sda_prev_q) begin
      idle_cnt_q <= '0;
    end else if (!timeout) begin
      idle_cnt_q <= idle_cnt_q + 20'h00001;
    end
  end

  assign timeout = idle_cnt_q >= TO_W'(TIMEOUT_CYCLES);

  // Strap observation during each address byte
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hi_seen_q <= 1'b0;
      lo_seen_q <= 1'b0;
      neq_sda_q <= 1'b0;
    end else if (start_ev) begin
      hi_seen_q <= 1'b0;
      lo_seen_q <= 1'b0;
      neq_sda_q <= 1'b0;
    end else if (state_q == ST_ADDR && bit_cnt_q < BIT_ACK) begin
      if (scl_rise) begin
        hi_seen_q <= hi_seen_q | strap_f;
        neq_sda_q <= neq_sda_q | (strap_f != sda_f);
      end
      if (scl_fall) begin
        lo_seen_q <= lo_seen_q | !strap_f;
      end
    end
  end

  // Decode strap connection to own address
  always_comb begin
    if (!hi_seen_q) begin
      own_addr = ADDR_GND;
    end else if (!lo_seen_q) begin
      own_addr = ADDR_VDD;
    end else if (!neq_sda_q) begin
      own_addr = ADDR_SDA;
    end else begin
      own_addr = ADDR_SCL;
    end
  end

  // High-speed filtering flag
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hs_q <= 1'b0;
    end else if (stop_ev) begin
      hs_q <= 1'b0;
    end else if (state_q == ST_ADDR && scl_fall && bit_cnt_q == BIT_ACK &&
                 shift_q[7:HS_CODE_POS] == HS_CODE_TOP) begin
      hs_q <= 1'b1;
    end
  end

  // Bit counter and receive shifter
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bit_cnt_q <= '0;
      shift_q <= '0;
      mack_q <= 1'b0;
    end else if (start_ev || stop_ev || timeout) begin
      bit_cnt_q <= '0;
    end else if (state_q != ST_IDLE) begin
      if (scl_rise) begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
        if (bit_cnt_q < BIT_ACK) begin
          shift_q <= {shift_q[6:0], sda_f};
        end else begin
          mack_q <= !sda_f;
        end
      end else if (scl_fall && bit_cnt_q == BIT_DONE) begin
        bit_cnt_q <= '0;
      end
    end
  end

  // Byte decoding, acknowledge and transmit control
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      pend_q <= ST_IDLE;
      sda_low_q <= 1'b0;
      tx_q <= '0;
      hi_q <= '0;
      rd_q <= '0;
      ptr_q <= PTR_RESET;
      byte_idx_q <= 1'b0;
      wr_q <= 1'b0;
      wdata_q <= '0;
      gc_q <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      gc_q <= 1'b0;
      if (start_ev) begin
        state_q <= ST_ADDR;
        sda_low_q <= 1'b0;
      end else if (stop_ev || timeout) begin
        state_q <= ST_IDLE;
        sda_low_q <= 1'b0;
      end else if (scl_fall && bit_cnt_q == BIT_ACK) begin
        // Eighth bit done: decide acknowledge for received bytes
        unique case (state_q)
          ST_ADDR: begin
            if (shift_q[7:1] == own_addr) begin
              sda_low_q <= 1'b1;
              pend_q <= shift_q[0] ? ST_TX : ST_PTR;
              rd_q <= reg_rdata;
            end else if (shift_q[7:1] == ADDR_GCALL && !shift_q[0]) begin
              sda_low_q <= 1'b1;
              pend_q <= ST_GCMD;
            end else begin
              sda_low_q <= 1'b0;
              pend_q <= ST_IGNORE;
            end
          end
          ST_PTR: begin
            ptr_q <= shift_q[PTR_W-1:0];
            sda_low_q <= 1'b1;
            byte_idx_q <= 1'b0;
            pend_q <= ST_DATA;
          end
          ST_GCMD: begin
            sda_low_q <= 1'b1;
            if (shift_q == GC_RESET_CMD) begin
              gc_q <= 1'b1;
              ptr_q <= PTR_RESET;
            end
            pend_q <= ST_IGNORE;
          end
          ST_DATA: begin
            sda_low_q <= 1'b1;
            if (!byte_idx_q) begin
              hi_q <= shift_q;
              byte_idx_q <= 1'b1;
              pend_q <= ST_DATA;
            end else begin
              wr_q <= 1'b1;
              wdata_q <= {hi_q, shift_q};
              pend_q <= ST_IGNORE;
            end
          end
          ST_TX: begin
            sda_low_q <= 1'b0;
          end
          ST_IGNORE, ST_IDLE: begin
            sda_low_q <= 1'b0;
          end
        endcase
      end else if (scl_fall && bit_cnt_q == BIT_DONE) begin
        // Ack clock done: release or load next transmit byte
        if (state_q == ST_TX) begin
          if (mack_q && !byte_idx_q) begin
            byte_idx_q <= 1'b1;
            tx_q <= {rd_q[6:0], 1'b0};
            sda_low_q <= !rd_q[7];
          end else begin
            state_q <= ST_IGNORE;
            sda_low_q <= 1'b0;
          end
        end else if (state_q == ST_ADDR && pend_q == ST_TX) begin
          state_q <= ST_TX;
          byte_idx_q <= 1'b0;
          tx_q <= {rd_q[14:8], 1'b0};
          sda_low_q <= !rd_q[15];
        end else begin
          state_q <= (state_q == ST_IGNORE) ? ST_IGNORE : pend_q;
          sda_low_q <= 1'b0;
        end
      end else if (scl_fall && state_q == ST_TX && bit_cnt_q < BIT_ACK) begin
        // Next bit shifted out while clock is low
        sda_low_q <= !tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // ********************************************
  // Outputs
  // ********************************************
  // Open drain: only ever pull low; clock line has no driver at all
  assign sda_o = 1'b0;
  assign sda_oe_n = !sda_low_q;
  assign reg_sel = ptr_q;
  assign reg_wr = wr_q;
  assign reg_wdata = wdata_q;
  assign gc_reset = gc_q;
  assign hs_mode = hs_q;
  assign busy = state_q != ST_IDLE;

endmodule : twi_target

// File: twi_target_checker.sv
`timescale 1ns/10ps
// ****
// Bus target port checks
// ****
module twi_target_checker
  import twi_target_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  input wire logic strap_i,
  input wire logic [PTR_W-1:0] reg_sel,
  input wire logic reg_wr,
  input wire logic [REG_W-1:0] reg_wdata,
  input wire logic [REG_W-1:0] reg_rdata,
  input wire logic gc_reset,
  input wire logic hs_mode,
  input wire logic busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic [1:0] lines_q;
  int idle_q;
  // Previous line levels
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) lines_q <= 2'h3;
    else lines_q <= {scl_i, sda_i};
  end
  // Busy cycles without line change
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) idle_q <= 0;
    else idle_q <= (!busy || lines_q != {scl_i, sda_i}) ? 0 : idle_q + 1;
  end
  property p_od; sda_o == 1'b0; endproperty
  a_od: assert property (p_od) else $error("data driven high");
  property p_oe_scl; $changed(sda_oe_n) |-> !scl_i; endproperty
  a_oe_scl: assert property (p_oe_scl) else $error("data moved with clock high");
  property p_ack_busy; !busy [*2] |-> sda_oe_n; endproperty
  a_ack_busy: assert property (p_ack_busy) else $error("data held while idle");
  property p_timeout; idle_q <= TIMEOUT_CYCLES + 10; endproperty
  a_timeout: assert property (p_timeout) else $error("idle timeout missed");
  property p_wr_pulse; reg_wr |-> busy ##1 !reg_wr; endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("bad write pulse");
  property p_gc; gc_reset |=> !gc_reset && reg_sel == PTR_RESET; endproperty
  a_gc: assert property (p_gc) else $error("bad general reset");
  property p_hs_entry; $rose(hs_mode) |-> busy; endproperty
  a_hs_entry: assert property (p_hs_entry) else $error("fast mode outside frame");
  property p_sel_keep; !busy [*2] |=> $stable(reg_sel); endproperty
  a_sel_keep: assert property (p_sel_keep) else $error("pointer lost");
  c_wr: cover property (reg_wr);
  c_gc: cover property (gc_reset);
  c_hs: cover property ($rose(hs_mode));
  c_to: cover property ($fell(busy) && !scl_i);
endmodule : twi_target_checker

bind twi_target twi_target_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) twi_target_checker_inst (
  .ref_clk(ref_clk), .nrst(nrst), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_n(sda_oe_n), .strap_i(strap_i), .reg_sel(reg_sel), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .gc_reset(gc_reset), .hs_mode(hs_mode),
  .busy(busy));

// File: twi_ctrl_model.sv
`timescale 1ns/10ps
// ****
// Bus controller on the far side
// ****
module twi_ctrl_model (
  output logic scl_low,
  output logic sda_low,
  input wire logic sda
);
  localparam int T = 625; // Quarter bit, 400 kHz
  int stall = 0;
  // Lines released at start, only ever pulled low
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // One bit: data set well after the clock fall, sampled mid high
  task automatic bit_io(input logic b, output logic s);
    #(T + stall) sda_low = !b;
    #(T) scl_low = 1'b0;
    #(T) s = sda;
    #(T) scl_low = 1'b1;
  endtask : bit_io
  // Start or repeated start
  task automatic bus_start;
    #(T) sda_low = 1'b0;
    #(T) scl_low = 1'b0;
    #(T) sda_low = 1'b1;
    #(T) scl_low = 1'b1;
  endtask : bus_start
  // Stop, lines left released
  task automatic bus_stop;
    #(T) sda_low = 1'b1;
    #(T) scl_low = 1'b0;
    #(T) sda_low = 1'b0;
    #(T);
  endtask : bus_stop
  // Byte out, MSB first, then ack clock
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask : wr_byte
  // Byte in, then controller ack or nack
  task automatic rd_byte(input logic mack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(!mack, s);
  endtask : rd_byte
  // Data line pulled or released directly, clock untouched
  task automatic data_level(input logic low);
    sda_low = low;
  endtask : data_level
endmodule : twi_ctrl_model

// File: testbench.sv
`timescale 1ns/10ps
// ****
// Bus target port bench
// ****
module testbench;
  import twi_target_pkg::*;
  localparam int TO_CYC = 200;
  logic ref_clk, nrst, strap_i, sda_o, sda_oe_n, reg_wr, gc_reset, hs_mode, busy;
  logic m_scl_low, m_sda_low;
  logic [1:0] strap_sel;
  logic [PTR_W-1:0] reg_sel;
  logic [REG_W-1:0] reg_wdata, reg_rdata, wr_data;
  int mismatches = 0, total_checks = 0, wr_cnt = 0, gc_cnt = 0;
  // Wired-and bus with pull-ups, strap and core read data
  wire scl = !m_scl_low;
  wire sda = !(m_sda_low || !sda_oe_n);
  assign strap_i = strap_sel == 2'h0 ? 1'b0 : strap_sel == 2'h1 ? 1'b1 : strap_sel == 2'h2 ? sda : scl;
  assign reg_rdata = {6'h2D, reg_sel, 6'h15, reg_sel};
  twi_target #(.TIMEOUT_CYCLES(TO_CYC)) twi_target_inst (.ref_clk(ref_clk), .nrst(nrst),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .strap_i(strap_i),
    .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .gc_reset(gc_reset), .hs_mode(hs_mode), .busy(busy));
  twi_ctrl_model twi_ctrl_model_inst (.scl_low(m_scl_low), .sda_low(m_sda_low), .sda(sda));
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Count write and general reset pulses
  always @(posedge ref_clk) begin
    if (reg_wr === 1'b1) begin
      wr_cnt++;
      wr_data = reg_wdata;
    end
    if (gc_reset === 1'b1) gc_cnt++;
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check
  task automatic wb(input logic [7:0] b, input logic exp);
    logic a;
    twi_ctrl_model_inst.wr_byte(b, a);
    check("ack", {15'h0000, exp}, {15'h0000, a});
  endtask : wb
  task automatic rw(input logic [15:0] exp);
    logic [7:0] hi, lo;
    twi_ctrl_model_inst.rd_byte(1'b1, hi);
    twi_ctrl_model_inst.rd_byte(1'b0, lo);
    check("read word", exp, {hi, lo});
  endtask : rw
  task automatic t_write;
    int n;
    n = wr_cnt;
    twi_ctrl_model_inst.stall = 3000;
    twi_ctrl_model_inst.bus_start();
    wb({ADDR_GND, 1'b0}, 1'b1);
    wb(8'h02, 1'b1);
    wb(8'hAB, 1'b1);
    wb(8'hCD, 1'b1);
    wb(8'h55, 1'b0);
    twi_ctrl_model_inst.bus_stop();
    twi_ctrl_model_inst.stall = 0;
    check("write count", 16'(n + 1), 16'(wr_cnt));
    check("write data", 16'hABCD, wr_data);
    check("pointer", {14'h0000, PTR_LO}, {14'h0000, reg_sel});
    $display("test write done");
  endtask : t_write
  task automatic t_read;
    for (int i = 0; i < 4; i++) begin
      twi_ctrl_model_inst.bus_start();
      wb({ADDR_GND, 1'b0}, 1'b1);
      wb(8'(i), 1'b1);
      twi_ctrl_model_inst.bus_start();
      wb({ADDR_GND, 1'b1}, 1'b1);
      rw({6'h2D, 2'(i), 6'h15, 2'(i)});
      twi_ctrl_model_inst.bus_stop();
      twi_ctrl_model_inst.bus_start();
      wb({ADDR_GND, 1'b1}, 1'b1);
      rw({6'h2D, 2'(i), 6'h15, 2'(i)});
      twi_ctrl_model_inst.bus_stop();
    end
    $display("test read done");
  endtask : t_read
  task automatic t_strap;
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk) #1 strap_sel = 2'(i);
      twi_ctrl_model_inst.bus_start();
      wb({ADDR_GND | 7'(i), 1'b0}, 1'b1);
      twi_ctrl_model_inst.bus_stop();
      twi_ctrl_model_inst.bus_start();
      wb({ADDR_GND | 7'(i ^ 1), 1'b0}, 1'b0);
      twi_ctrl_model_inst.bus_stop();
    end
    @(posedge ref_clk) #1 strap_sel = 2'h0;
    $display("test strap done");
  endtask : t_strap
  task automatic t_gcall;
    int n;
    n = gc_cnt;
    twi_ctrl_model_inst.bus_start();
    wb({ADDR_GND, 1'b0}, 1'b1);
    wb(8'h03, 1'b1);
    twi_ctrl_model_inst.bus_start();
    wb({ADDR_GCALL, 1'b0}, 1'b1);
    wb(GC_RESET_CMD, 1'b1);
    twi_ctrl_model_inst.bus_stop();
    check("general reset", 16'(n + 1), 16'(gc_cnt));
    check("pointer", {14'h0000, PTR_RESET}, {14'h0000, reg_sel});
    twi_ctrl_model_inst.bus_start();
    wb({ADDR_GCALL, 1'b0}, 1'b1);
    wb(8'h04, 1'b1);
    twi_ctrl_model_inst.bus_stop();
    check("general reset", 16'(n + 1), 16'(gc_cnt));
    twi_ctrl_model_inst.bus_start();
    wb({ADDR_GCALL, 1'b1}, 1'b0);
    twi_ctrl_model_inst.bus_stop();
    $display("test general call done");
  endtask : t_gcall
  task automatic t_hs;
    twi_ctrl_model_inst.bus_start();
    wb({HS_CODE_TOP, 3'h5}, 1'b0);
    check("fast mode", 16'h0001, {15'h0000, hs_mode});
    twi_ctrl_model_inst.bus_start();
    wb({ADDR_GND, 1'b0}, 1'b1);
    twi_ctrl_model_inst.bus_stop();
    check("fast mode", 16'h0000, {15'h0000, hs_mode});
    $display("test fast mode done");
  endtask : t_hs
  task automatic t_timeout;
    int k;
    twi_ctrl_model_inst.bus_start();
    wb({ADDR_GND, 1'b0}, 1'b1);
    for (k = 0; k < TO_CYC + 100 && busy !== 1'b0; k++) @(posedge ref_clk) #1;
    check("idle after stall", 16'h0000, {15'h0000, busy});
    check("stall length", 16'h0001, {15'h0000, k > TO_CYC - 20});
    twi_ctrl_model_inst.bus_stop();
    $display("test timeout done");
  endtask : t_timeout
  task automatic t_glitch;
    @(posedge ref_clk) #1 twi_ctrl_model_inst.data_level(1'b1);
    @(posedge ref_clk) #1 twi_ctrl_model_inst.data_level(1'b0);
    repeat (8) @(posedge ref_clk);
    #1 check("busy after glitch", 16'h0000, {15'h0000, busy});
    twi_ctrl_model_inst.data_level(1'b1);
    repeat (8) @(posedge ref_clk);
    #1 check("busy after start", 16'h0001, {15'h0000, busy});
    twi_ctrl_model_inst.bus_stop();
    check("busy after stop", 16'h0000, {15'h0000, busy});
    $display("test glitch done");
  endtask : t_glitch
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  // Main sequence
  initial begin
    nrst = 1'b0;
    strap_sel = 2'h0;
    repeat (16) @(posedge ref_clk);
    #1 nrst = 1'b1;
    repeat (8) @(posedge ref_clk);
    t_glitch();
    t_write();
    t_read();
    t_strap();
    t_gcall();
    t_hs();
    t_timeout();
    finish_test();
  end
  // Hang guard
  initial begin
    #4ms;
    mismatches++;
    finish_test();
  end
endmodule : testbench
